// file: shared/flash_regs_consts.svh
// Purpose: Offsets, field positions, reset values and fixed codes of the flash address register bank.
// Assumes: Word offsets are register indices; the AHB byte address is four times the index.
// Notes:   Definitions only.
`ifndef FLASH_REGS_CONSTS_SVH
`define FLASH_REGS_CONSTS_SVH

// ==========================================================================
// Register indices
`define IDX_MAKER_CODE           16'hf000
`define IDX_PART_CODE            16'hf001
`define IDX_PAGE_BUF_CAPACITY    16'hf003
`define IDX_STARTUP_BUF_CAPACITY 16'hf004
`define IDX_BUFFER_COUNTS        16'hf005
`define IDX_CELL_TECHNOLOGY      16'hf006
`define IDX_TARGET_BLOCK         16'hf100
`define IDX_SPARE_ADDRESS_SLOT   16'hf101
`define IDX_COPY_DEST_BLOCK      16'hf102
`define IDX_COPY_DEST_PAGE_SECT  16'hf103
`define IDX_TARGET_PAGE_SECT     16'hf107
`define IDX_BUFFER_SELECT        16'hf200
`define IDX_BUFFER_STATUS        16'hf201

// ==========================================================================
// Fixed values
`define VAL_MAKER_CODE           16'h0a5a
`define VAL_PART_CODE_LOW_VCC    16'h0011
`define VAL_PART_CODE_HIGH_VCC   16'h0012
`define VAL_PAGE_BUF_CAPACITY    16'h0400
`define VAL_STARTUP_BUF_CAPACITY 16'h0200
`define VAL_BUFFER_COUNTS        16'h0201
`define VAL_TECH_SLC             16'h0000
`define VAL_TECH_MLC             16'h0001
`define VAL_ZERO16               16'h0000

// ==========================================================================
// Field positions
`define BLOCK_MSB                7
`define PAGE_MSB                 7
`define PAGE_LSB                 2
`define SECTOR_BIT               0
`define BSA_MSB                  11
`define BSA_LSB                  8
`define BSA_STARTUP_PAGE_BIT     3
`define BSA_PAGE_BUF_BIT         2
`define BSA_SECTOR_BIT           0
`define BSC_BIT                  0
`define RESP_OKAY                1'b0
`define HTRANS_NONSEQ_BIT        1
`endif

// file: shared/flash_regs_pkg.sv
// Purpose: Types of the flash address register bank.
// Assumes: Nothing beyond the constants header.
// Notes:   Types only.
// ==========================================================================
// Types
package flash_regs_pkg;
  typedef enum logic [1:0] {
    XFER_IDLE   = 2'b00,
    XFER_FIRST  = 2'b01,
    XFER_SECOND = 2'b10
  } xfer_state_e;
endpackage

// file: src/flash_address_buffer_registers.sv
// Purpose: Host-visible identification, address and buffer-select registers over AHB-Lite.
// Assumes: Single 32-bit word transfers; data in low 16 bits; zero-wait slave.
// Notes:   A transfer sequencer walks the selected buffer sectors on request.
`timescale 1ns/1ps
`default_nettype none
`include "flash_regs_consts.svh"

module flash_address_buffer_registers (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Part strap
  input  wire logic        highVccPart,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Flash array sequencer
  input  wire logic        arrayStart,
  input  wire logic        arrayStep,
  output logic      [3:0]  activeSector,
  output logic             arrayBusy,
  output logic             startupBlocked,
  output logic             pageZeroBlocked,
  // Address outputs
  output logic      [7:0]  targetBlockNumber,
  output logic      [7:0]  copyDestBlockNumber,
  output logic      [5:0]  copyDestPageNumber,
  output logic             copyDestSectorNumber,
  output logic      [5:0]  startPageNumber,
  output logic             startSectorNumber,
  output logic      [3:0]  bufferSectorSelect,
  output logic             transferSectorCount
);

  // ========================================================================
  // Decoding helpers
  function automatic logic [15:0] word_index(input logic [31:0] a);
    word_index = a[17:2];
  endfunction

  // The upper byte of every eight-bit field register is reserved and reads zero.
  function automatic logic [15:0] pad8(input logic [7:0] v);
    pad8 = {8'h00, v};
  endfunction

  // ========================================================================
  // Input synchronisers and strap capture
  logic       strapMeta;
  logic       strapSync;
  logic       startMeta;
  logic       startSync;
  logic       stepMeta;
  logic       stepSync;
  logic       startPrev;
  logic       stepPrev;
  logic       partHigh;
  logic       strapTaken;

  always_ff @(posedge clock) begin
    strapMeta <= highVccPart;
    strapSync <= strapMeta;
    startMeta <= arrayStart;
    startSync <= startMeta;
    stepMeta  <= arrayStep;
    stepSync  <= stepMeta;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      startPrev <= 1'b0;
      stepPrev  <= 1'b0;
    end else begin
      startPrev <= startSync;
      stepPrev  <= stepSync;
    end
  end

  // The strap is sampled once after reset release; a running part does not change variant.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strapTaken <= 1'b0;
      partHigh   <= 1'b0;
    end else if (!strapTaken) begin
      strapTaken <= 1'b1;
      partHigh   <= strapSync;
    end
  end

  wire startPulse = startSync & ~startPrev;
  wire stepPulse  = stepSync & ~stepPrev;

  // ========================================================================
  // AHB-Lite address phase capture
  logic        dataPhase;
  logic        dataWrite;
  logic [15:0] dataIndex;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataIndex <= `VAL_ZERO16;
    end else if (hready) begin
      dataPhase <= hsel & htrans[`HTRANS_NONSEQ_BIT];
      dataWrite <= hwrite;
      dataIndex <= word_index(haddr);
    end
  end


  // ========================================================================
  // Data phase decode
  wire         wrEn  = dataPhase & dataWrite;
  wire  [15:0] wdata = hwdata[15:0];

  // ========================================================================
  // Writable registers; reserved bits are not stored, so they read as zero.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      targetBlockNumber <= 8'h00;
    end else if (wrEn && dataIndex == `IDX_TARGET_BLOCK) begin
      targetBlockNumber <= wdata[`BLOCK_MSB:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      copyDestBlockNumber <= 8'h00;
    end else if (wrEn && dataIndex == `IDX_COPY_DEST_BLOCK) begin
      copyDestBlockNumber <= wdata[`BLOCK_MSB:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      copyDestPageNumber   <= 6'h00;
      copyDestSectorNumber <= 1'b0;
    end else if (wrEn && dataIndex == `IDX_COPY_DEST_PAGE_SECT) begin
      copyDestPageNumber   <= wdata[`PAGE_MSB:`PAGE_LSB];
      copyDestSectorNumber <= wdata[`SECTOR_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      startPageNumber   <= 6'h00;
      startSectorNumber <= 1'b0;
    end else if (wrEn && dataIndex == `IDX_TARGET_PAGE_SECT) begin
      startPageNumber   <= wdata[`PAGE_MSB:`PAGE_LSB];
      startSectorNumber <= wdata[`SECTOR_BIT];
    end
  end

  // Rewriting the select while the array is busy would corrupt the running walk, so it is held.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bufferSectorSelect  <= 4'h0;
      transferSectorCount <= 1'b0;
    end else if (wrEn && dataIndex == `IDX_BUFFER_SELECT && !arrayBusy) begin
      bufferSectorSelect  <= wdata[`BSA_MSB:`BSA_LSB];
      transferSectorCount <= wdata[`BSC_BIT];
    end
  end

  // ========================================================================
  // Buffer transfer sequencer
  flash_regs_pkg::xfer_state_e state;
  flash_regs_pkg::xfer_state_e next_state;

  // A start seen while a walk runs is dropped; the walk must finish first.
  always_comb begin
    next_state = state;
    case (state)
      flash_regs_pkg::XFER_IDLE: begin
        if (startPulse) begin
          next_state = flash_regs_pkg::XFER_FIRST;
        end
      end
      flash_regs_pkg::XFER_FIRST: begin
        if (stepPulse) begin
          next_state = transferSectorCount ? flash_regs_pkg::XFER_IDLE
                                           : flash_regs_pkg::XFER_SECOND;
        end
      end
      flash_regs_pkg::XFER_SECOND: begin
        if (stepPulse) begin
          next_state = flash_regs_pkg::XFER_IDLE;
        end
      end
      default: begin
        next_state = flash_regs_pkg::XFER_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= flash_regs_pkg::XFER_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      activeSector <= 4'h0;
    end else if (state == flash_regs_pkg::XFER_IDLE && startPulse) begin
      activeSector <= bufferSectorSelect;
    end else if (state == flash_regs_pkg::XFER_FIRST && stepPulse) begin
      // Bit 0 toggles: a walk from sector 0 moves to sector 1, and from sector 1, the top, it wraps to sector 0 of the same buffer.
      activeSector <= {activeSector[3:1], ~activeSector[`BSA_SECTOR_BIT]};
    end
  end

  // ========================================================================
  // Host RAM blocking flags

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arrayBusy       <= 1'b0;
      startupBlocked  <= 1'b0;
      pageZeroBlocked <= 1'b0;
    end else begin
      arrayBusy <= (next_state != flash_regs_pkg::XFER_IDLE);
      if (next_state == flash_regs_pkg::XFER_IDLE) begin
        startupBlocked  <= 1'b0;
        pageZeroBlocked <= 1'b0;
      end else if (state == flash_regs_pkg::XFER_IDLE) begin
        // Startup RAM in use blocks page buffer zero and the other way round.
        startupBlocked  <= bufferSectorSelect[`BSA_STARTUP_PAGE_BIT]
                           & ~bufferSectorSelect[`BSA_PAGE_BUF_BIT];
        pageZeroBlocked <= ~bufferSectorSelect[`BSA_STARTUP_PAGE_BIT];
      end
    end
  end

  // ========================================================================
  // Read mux
  logic [15:0] readWord;

  // Reserved bits are tied to zero in every readback word.
  always_comb begin
    case (word_index(haddr))
      `IDX_MAKER_CODE:           readWord = `VAL_MAKER_CODE;
      `IDX_PART_CODE:            readWord = partHigh ? `VAL_PART_CODE_HIGH_VCC : `VAL_PART_CODE_LOW_VCC;
      `IDX_PAGE_BUF_CAPACITY:    readWord = `VAL_PAGE_BUF_CAPACITY;
      `IDX_STARTUP_BUF_CAPACITY: readWord = `VAL_STARTUP_BUF_CAPACITY;
      `IDX_BUFFER_COUNTS:        readWord = `VAL_BUFFER_COUNTS;
      `IDX_CELL_TECHNOLOGY:      readWord = `VAL_TECH_SLC;
      `IDX_TARGET_BLOCK:         readWord = pad8(targetBlockNumber);
      `IDX_SPARE_ADDRESS_SLOT:   readWord = `VAL_ZERO16;
      `IDX_COPY_DEST_BLOCK:      readWord = pad8(copyDestBlockNumber);
      `IDX_COPY_DEST_PAGE_SECT:  readWord = pad8({copyDestPageNumber, 1'b0, copyDestSectorNumber});
      `IDX_TARGET_PAGE_SECT:     readWord = pad8({startPageNumber, 1'b0, startSectorNumber});
      `IDX_BUFFER_SELECT:        readWord = {4'h0, bufferSectorSelect, 7'h00, transferSectorCount};
      `IDX_BUFFER_STATUS:        readWord = {activeSector, 9'h000, startupBlocked, pageZeroBlocked, arrayBusy};
      default:                   readWord = `VAL_ZERO16;
    endcase
  end

  // Read data is registered at the address phase so the data phase needs no wait state.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[`HTRANS_NONSEQ_BIT] && !hwrite) begin
      hrdata <= {16'h0000, readWord};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp     <= `RESP_OKAY;
    end else begin
      // No transfer is ever stretched, so ready stays high once reset is gone.
      hreadyout <= 1'b1;
      hresp     <= `RESP_OKAY;
    end
  end

endmodule // flash_address_buffer_registers
`default_nettype wire

// file: sim/flash_regs_properties.sv
// Purpose: Bus and transfer properties of the flash register bank.
// Assumes: Zero-wait slave; byte address is four times the index.
// Notes:   Bound to the design top.
`timescale 1ns/1ps
`default_nettype none
`include "flash_regs_consts.svh"
module flash_regs_properties (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Transfer
  input wire logic        arrayBusy,
  input wire logic [3:0]  activeSector,
  input wire logic        startupBlocked,
  input wire logic        pageZeroBlocked,
  input wire logic [7:0]  targetBlockNumber,
  input wire logic [3:0]  bufferSectorSelect,
  input wire logic        transferSectorCount
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Properties
  logic taken;
  assign taken = hsel && hready && htrans[1];
  a_resp_okay: assert property (hresp == `RESP_OKAY) else $error("hresp not okay");
  a_ready_after_reset: assert property ($past(rst_n) |-> hreadyout) else $error("hreadyout low");
  a_maker_read: assert property (taken && !hwrite && haddr == {14'h0, `IDX_MAKER_CODE, 2'h0}
    |=> hrdata == {16'h0, `VAL_MAKER_CODE}) else $error("maker code wrong");
  a_block_write: assert property (taken && hwrite && haddr == {14'h0, `IDX_TARGET_BLOCK, 2'h0} ##1 1'b1
    |=> targetBlockNumber == $past(hwdata[7:0])) else $error("block not written");
  a_ram_blocking: assert property (pageZeroBlocked == (arrayBusy && !activeSector[3])
    && startupBlocked == (arrayBusy && activeSector[3:2] == 2'h2)) else $error("blocking wrong");
  a_first_sector: assert property ($rose(arrayBusy) |-> activeSector == bufferSectorSelect)
    else $error("first sector wrong");
  a_sector_wrap: assert property (arrayBusy && $past(arrayBusy) && $changed(activeSector)
    |-> !transferSectorCount && activeSector == ($past(activeSector) ^ 4'h1)) else $error("bad wrap");
  a_last_sector: assert property ($fell(arrayBusy)
    |-> $past(activeSector) == (bufferSectorSelect ^ {3'h0, !transferSectorCount})) else $error("bad end");
  cover property ($rose(arrayBusy) && transferSectorCount);
  cover property ($rose(arrayBusy) && !transferSectorCount);
  cover property (taken && hwrite);
endmodule // flash_regs_properties

bind flash_address_buffer_registers flash_regs_properties flash_regs_properties_inst (
  .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .arrayBusy(arrayBusy), .activeSector(activeSector), .startupBlocked(startupBlocked),
  .pageZeroBlocked(pageZeroBlocked), .targetBlockNumber(targetBlockNumber),
  .bufferSectorSelect(bufferSectorSelect), .transferSectorCount(transferSectorCount)
);
`default_nettype wire

// file: sim/host_bus_model.sv
// Purpose: Host bus master for the flash register bank.
// Assumes: Single word transfers to one slave.
// Notes:   Released write data is inverted, so a stale value never matches.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // Clock
  input  wire logic        clock,
  // Bus
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  int timeouts = 0;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      timeouts++;
    end
  endtask
  task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] wdata,
                        output logic [31:0] rdata);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    waitReady();
    htrans <= 2'h0;
    hwdata <= {16'h0, wdata};
    waitReady();
    rdata = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule // host_bus_model
`default_nettype wire

// file: sim/flash_address_buffer_registers_test.sv
// Purpose: Self-checking bench for the flash register bank.
// Assumes: Zero-wait slave; transfer inputs are driven here.
// Notes:   A second reset switches the supply strap.
`timescale 1ns/1ps
`default_nettype none
`include "flash_regs_consts.svh"
module flash_address_buffer_registers_test;
  // ==========================================================================
  // Signals
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        highVccPart = 1'b0;
  logic        arrayStart = 1'b0;
  logic        arrayStep = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, arrayBusy, startupBlocked, pageZeroBlocked;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  activeSector, bufferSectorSelect;
  logic [7:0]  targetBlockNumber, copyDestBlockNumber;
  logic [5:0]  copyDestPageNumber, startPageNumber;
  logic        copyDestSectorNumber, startSectorNumber, transferSectorCount;
  logic [34:0] fieldBits;
  int          fails = 0;
  int          checks = 0;
  logic [47:0] tbl [13] = '{
    {`IDX_MAKER_CODE, `VAL_MAKER_CODE, `VAL_MAKER_CODE},
    {`IDX_PART_CODE, `VAL_PART_CODE_LOW_VCC, `VAL_PART_CODE_LOW_VCC},
    {`IDX_PAGE_BUF_CAPACITY, 32'h0400_0400}, {`IDX_STARTUP_BUF_CAPACITY, 32'h0200_0200},
    {`IDX_BUFFER_COUNTS, 32'h0201_0201}, {`IDX_CELL_TECHNOLOGY, 32'h0000_0000},
    {`IDX_TARGET_BLOCK, 32'h0000_00ff}, {`IDX_SPARE_ADDRESS_SLOT, 32'h0000_0000},
    {`IDX_COPY_DEST_BLOCK, 32'h0000_00ff}, {`IDX_COPY_DEST_PAGE_SECT, 32'h0000_00fd},
    {`IDX_TARGET_PAGE_SECT, 32'h0000_00fd}, {`IDX_BUFFER_SELECT, 32'h0000_0f01}, 48'hf104_0000_0000};
  assign fieldBits = {targetBlockNumber, copyDestBlockNumber, copyDestPageNumber, copyDestSectorNumber,
                      startPageNumber, startSectorNumber, bufferSectorSelect, transferSectorCount};
  always #10 clock = ~clock;
  flash_address_buffer_registers flash_address_buffer_registers_inst (
    .clock(clock), .rst_n(rst_n), .highVccPart(highVccPart), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .arrayStart(arrayStart), .arrayStep(arrayStep),
    .activeSector(activeSector), .arrayBusy(arrayBusy), .startupBlocked(startupBlocked),
    .pageZeroBlocked(pageZeroBlocked), .targetBlockNumber(targetBlockNumber),
    .copyDestBlockNumber(copyDestBlockNumber), .copyDestPageNumber(copyDestPageNumber),
    .copyDestSectorNumber(copyDestSectorNumber), .startPageNumber(startPageNumber),
    .startSectorNumber(startSectorNumber), .bufferSectorSelect(bufferSectorSelect),
    .transferSectorCount(transferSectorCount));
  host_bus_model host_bus_model_inst (
    .clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ==========================================================================
  // Tasks
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    fails += host_bus_model_inst.timeouts;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic regRead(input logic [15:0] idx, input logic [15:0] exp);
    host_bus_model_inst.access(1'b0, idx, 16'h0000, rd);
    check("register", {16'h0, rd}, {32'h0, exp});
  endtask
  // A bounded wait; running out of cycles ends the run.
  task automatic await(input string what, input logic [3:0] exp, input logic sector);
    logic [3:0] seen;
    for (int n = 0; n < 40; n++) begin
      @(posedge clock);
      #1;
      seen = sector ? activeSector : {3'h0, arrayBusy};
      if (seen === exp) break;
    end
    check(what, {44'h0, seen}, {44'h0, exp});
    if (seen !== exp) results();
  endtask
  // Held for four edges so the two-flop synchroniser always sees it.
  task automatic pulse(input logic step);
    @(posedge clock);
    arrayStart <= !step;
    arrayStep <= step;
    repeat (4) @(posedge clock);
    arrayStart <= 1'b0;
    arrayStep <= 1'b0;
  endtask
  task automatic xfer(input logic [15:0] sel);
    @(posedge clock);
    host_bus_model_inst.access(1'b1, `IDX_BUFFER_SELECT, sel, rd);
    pulse(1'b0);
    await("busy", 4'h1, 1'b0);
    check("sector", {44'h0, activeSector}, {44'h0, sel[11:8]});
    check("blocks", {46'h0, startupBlocked, pageZeroBlocked}, {46'h0, sel[11:10] == 2'h2, !sel[11]});
    if (!sel[0]) begin
      pulse(1'b1);
      await("wrap", sel[11:8] ^ 4'h1, 1'b1);
    end
    pulse(1'b1);
    await("done", 4'h0, 1'b0);
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 13; i++) begin
      regRead(tbl[i][47:32], tbl[i][31:16]);
      host_bus_model_inst.access(1'b1, tbl[i][47:32], 16'hffff, rd);
      regRead(tbl[i][47:32], tbl[i][15:0]);
    end
    #1;
    check("fields", {13'h0, fieldBits}, 48'h0007_ffff_ffff);
    xfer(16'h0d00);
    xfer(16'h0800);
    xfer(16'h0101);
    @(posedge clock);
    highVccPart <= 1'b1;
    rst_n <= 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    regRead(`IDX_PART_CODE, `VAL_PART_CODE_HIGH_VCC);
    regRead(`IDX_TARGET_BLOCK, `VAL_ZERO16);
    results();
  end
endmodule // flash_address_buffer_registers_test
`default_nettype wire
